// ===== hw/sfwp_pkg.sv
// package for the serial flash write-protection block
package sfwp_pkg;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
    localparam logic [7:0] CMD_READ_CONFIG = 8'hA1;
    localparam logic [7:0] CMD_WRITE_CONFIG = 8'hF1;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'hD7;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] CMD_WHOLE_ERASE = 8'hC7;
    localparam int ST_SWD_BIT = 7;
    localparam int ST_BP_LSB = 2;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_WIP_BIT = 0;
    localparam int CMD_BITS = 8;
    localparam int ADDR_CMD_BITS = 32;
    localparam int REG_WR_BITS = 16;
    localparam int PAGE_BYTES = 256;
    localparam logic [2:0] BP_RESET = 3'h0;
    localparam logic SWD_RESET = 1'b0;
    localparam logic [4:0] CFG_RESET = 5'h00;
    localparam int WRITE_TIME_US = 20;
    localparam int CLK_MHZ = 10;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    typedef struct packed {
        logic swd;
        logic [2:0] bp;
    } sfwp_nv_t;
    typedef struct packed {
        logic [3:0] sub_sector_protect;
        logic small_sector_mode;
    } sfwp_cfg_t;
endpackage : sfwp_pkg

// ===== hw/sfwp_core.sv
// spi write-protection and status logic of a serial flash
//
// Behaviour
// - small-sector mode set only when all protect bits one
// - protect bits all zero clear small-sector mode
// - sub-sector bits protect 1KB pieces in mode
// - config register written and read back by commands
// - status layout swd,0,0,bp,latch,busy
// - protect and swd bits keep value, default zero
// - busy flag one during internal write cycle
// - cleared latch inhibits every write command
// - write-enable command sets latch before writes
// - latch cleared by disable and at the frame end of each write command with a valid clock count
// - program/erase refused inside protected area
// - whole erase only with protect bits zero
// - small-sector mode decides sector 0 by sub-bits
// - swd and low wp pin block status write
// - two-bit variant quarter/half/all decoding, only all when ADDR_W <= 16
// - three-bit variant eighth/quarter/half/all decoding
// - program needs 32 clocks plus whole bytes
// - wrong clock count voids write command
// - config bits reset to zero
// - latch resets write-disabled
// - during write only read-status and read-config accepted
`timescale 1ns/100ps
module sfwp_core
    import sfwp_pkg::*;
#(
    parameter int ADDR_W = 19,
    parameter int BP_BITS = 3,
    parameter int WRITE_CYC = WRITE_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // spi pins
    input wire logic ce_b_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic wp_b_i,
    output logic so_o,
    output logic so_oe_o,
    // array operation strobe
    output logic prog_go_o,
    output logic erase_go_o,
    output logic [ADDR_W-1:0] op_addr_o
);
    logic [2:0] ce_s, sck_s, si_s, wp_s;
    logic ce_q, sck_q, si_q, wp_q, sck_d;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ce_s <= 3'h7;
            sck_s <= 3'h0;
            si_s <= 3'h0;
            wp_s <= 3'h7;
            sck_d <= 1'b0;
        end else begin
            ce_s <= {ce_s[1:0], ce_b_i};
            sck_s <= {sck_s[1:0], sck_i};
            si_s <= {si_s[1:0], si_i};
            wp_s <= {wp_s[1:0], wp_b_i};
            sck_d <= sck_s[1];
        end
    end
    assign ce_q = ce_s[1];
    assign sck_q = sck_s[1];
    assign si_q = si_s[1];
    assign wp_q = wp_s[1];
    wire rise = sck_q && !sck_d && !ce_q;
    wire fall = !sck_q && sck_d && !ce_q;
    logic ce_d;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) ce_d <= 1'b1;
        else ce_d <= ce_q;
    end
    wire frame_end = ce_q && !ce_d;
    logic [7:0] cmd, next_cmd;
    logic [31:0] shreg, next_shreg;
    logic [12:0] bitcnt, next_bitcnt;
    logic [7:0] tx, next_tx;
    sfwp_nv_t nv, next_nv;
    sfwp_cfg_t cfg, next_cfg;
    logic write_enable_latch, next_wel;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [15:0] busy_cnt, next_busy_cnt;
    logic so, next_so, so_oe, next_so_oe, pgo, next_pgo, ego, next_ego;
    logic [ADDR_W-1:0] oaddr, next_oaddr;
    wire write_in_progress = busy_cnt != 16'h0000;
    wire [7:0] status = {nv.swd, 2'b00, nv.bp, write_enable_latch, write_in_progress};
    function automatic logic prot(input logic [ADDR_W-1:0] a, input sfwp_nv_t n,
                                  input sfwp_cfg_t c);
        logic p;
        logic [2:0] top;
        p = 1'b0;
        top = a[ADDR_W-1 -: 3];
        if (BP_BITS == 3) begin
            if (n.bp[2]) p = 1'b1;
            else if (n.bp[1:0] == 2'b01) p = (top == 3'h7);
            else if (n.bp[1:0] == 2'b10) p = top[2] && top[1];
            else if (n.bp[1:0] == 2'b11) p = top[2];
        end else begin
            if (n.bp[1:0] == 2'b11) p = 1'b1;
            else if (ADDR_W <= 16) p = 1'b0;
            else if (n.bp[1:0] == 2'b01) p = top[2] && top[1];
            else if (n.bp[1:0] == 2'b10) p = top[2];
        end
        if (c.small_sector_mode && a[ADDR_W-1:12] == '0) begin
            p = c.sub_sector_protect[a[11:10]];
        end
        return p;
    endfunction : prot
    always_comb begin
        next_cmd = cmd;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_tx = tx;
        next_nv = nv;
        next_cfg = cfg;
        next_wel = write_enable_latch;
        next_addr = addr;
        next_so = so;
        next_so_oe = so_oe;
        next_pgo = 1'b0;
        next_ego = 1'b0;
        next_oaddr = oaddr;
        next_busy_cnt = write_in_progress ? busy_cnt - 16'h0001 : busy_cnt;
        if (ce_q) begin
            next_bitcnt = '0;
            next_so_oe = 1'b0;
        end
        if (rise) begin
            next_shreg = {shreg[30:0], si_q};
            next_bitcnt = bitcnt + 13'h0001;
            if (bitcnt == 13'(CMD_BITS - 1)) begin
                next_cmd = {shreg[6:0], si_q};
                if (next_cmd == CMD_READ_STATUS) next_tx = status;
                if (next_cmd == CMD_READ_CONFIG) next_tx = {3'b000, cfg};
            end
            if (bitcnt == 13'(ADDR_CMD_BITS - 1)) begin
                next_addr = ADDR_W'({shreg[22:0], si_q});
            end
        end
        if (fall && bitcnt >= 13'(CMD_BITS) && (cmd == CMD_READ_STATUS
            || cmd == CMD_READ_CONFIG)) begin
            next_so_oe = 1'b1;
            next_so = tx[7];
            next_tx = {tx[6:0], tx[7]};
            if (bitcnt[2:0] == 3'h0) begin
                if (cmd == CMD_READ_STATUS) begin
                    next_so = status[7];
                    next_tx = {status[6:0], status[7]};
                end else begin
                    // config reads back as 000 + sub bits + mode, bit 7 first
                    next_so = 1'b0;
                    next_tx = {2'b00, cfg, 1'b0};
                end
            end
        end
        if (frame_end && !write_in_progress) begin
            if (bitcnt == 13'(CMD_BITS) && cmd == CMD_WRITE_ENABLE) next_wel = 1'b1;
            if (bitcnt == 13'(CMD_BITS) && cmd == CMD_WRITE_DISABLE) next_wel = 1'b0;
            if (write_enable_latch) begin
                if (cmd == CMD_WRITE_STATUS && bitcnt == 13'(REG_WR_BITS)) begin
                    next_wel = 1'b0;
                    if (!(nv.swd && !wp_q)) begin
                        next_nv.swd = shreg[ST_SWD_BIT];
                        next_nv.bp = shreg[ST_BP_LSB +: 3] & 3'(2**BP_BITS - 1);
                        next_busy_cnt = 16'(WRITE_CYC);
                        if (next_nv.bp == 3'h0) next_cfg.small_sector_mode = 1'b0;
                    end
                end
                if (cmd == CMD_WRITE_CONFIG && bitcnt == 13'(REG_WR_BITS)) begin
                    next_wel = 1'b0;
                    next_cfg.sub_sector_protect = shreg[4:1];
                    next_cfg.small_sector_mode = shreg[0]
                        && (nv.bp == 3'(2**BP_BITS - 1));
                end
                if (cmd == CMD_PAGE_PROG && bitcnt > 13'(ADDR_CMD_BITS)
                    && bitcnt <= 13'(ADDR_CMD_BITS + 8 * PAGE_BYTES)
                    && bitcnt[2:0] == 3'h0) begin
                    next_wel = 1'b0;
                    if (!prot(addr, nv, cfg)) begin
                        next_pgo = 1'b1;
                        next_oaddr = addr;
                        next_busy_cnt = 16'(WRITE_CYC);
                    end
                end
                if ((cmd == CMD_SECTOR_ERASE || cmd == CMD_BLOCK_ERASE)
                    && bitcnt == 13'(ADDR_CMD_BITS)) begin
                    next_wel = 1'b0;
                    if (!prot(addr, nv, cfg)) begin
                        next_ego = 1'b1;
                        next_oaddr = addr;
                        next_busy_cnt = 16'(WRITE_CYC);
                    end
                end
                if (cmd == CMD_WHOLE_ERASE && bitcnt == 13'(CMD_BITS)) begin
                    next_wel = 1'b0;
                    if (nv.bp == 3'h0) begin
                        next_ego = 1'b1;
                        next_oaddr = '0;
                        next_busy_cnt = 16'(WRITE_CYC);
                    end
                end
            end
        end
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd <= 8'h00;
            shreg <= 32'h0000_0000;
            bitcnt <= 13'h0000;
            tx <= 8'h00;
            nv <= {SWD_RESET, BP_RESET};
            cfg <= CFG_RESET;
            write_enable_latch <= 1'b0;
            addr <= '0;
            busy_cnt <= 16'h0000;
            so <= 1'b0;
            so_oe <= 1'b0;
            pgo <= 1'b0;
            ego <= 1'b0;
            oaddr <= '0;
        end else begin
            cmd <= next_cmd;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            tx <= next_tx;
            nv <= next_nv;
            cfg <= next_cfg;
            write_enable_latch <= next_wel;
            addr <= next_addr;
            busy_cnt <= next_busy_cnt;
            so <= next_so;
            so_oe <= next_so_oe;
            pgo <= next_pgo;
            ego <= next_ego;
            oaddr <= next_oaddr;
        end
    end
    assign so_o = so;
    assign so_oe_o = so_oe;
    assign prog_go_o = pgo;
    assign erase_go_o = ego;
    assign op_addr_o = oaddr;
    busy_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (pgo || ego) |=> write_in_progress) else $error("busy not raised");
    wel_clr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (pgo || ego) |-> !write_enable_latch) else $error("latch not cleared");
    inhibit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!write_enable_latch ##1 (pgo || ego)) |-> 1'b0) else $error("write without latch");
    chip_bp_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ego && oaddr == '0 && $past(cmd) == CMD_WHOLE_ERASE) |-> nv.bp == 3'h0)
        else $error("whole erase while protected");
    ssm_bp_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(cfg.small_sector_mode) |-> $past(nv.bp) == 3'(2**BP_BITS - 1))
        else $error("small mode without full protect");
    ssm_clr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (nv.bp == 3'h0 && $changed(nv.bp)) |-> !cfg.small_sector_mode)
        else $error("small mode kept");
    hw_lock_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ($past(nv.swd) && !$past(wp_q)) |-> $stable(nv))
        else $error("locked status changed");
    busy_block_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $past(write_in_progress) |-> !$rose(write_enable_latch)) else $error("command taken while busy");
    prot_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        pgo |-> !prot(oaddr, nv, cfg)) else $error("protected program");

    // checks on accepted array operations and register writes

    prog_len_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        pgo |-> ($past(bitcnt[2:0]) == 3'h0 && $past(bitcnt) > 13'(ADDR_CMD_BITS)))
        else $error("program with partial byte");

    erase_len_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ego && cmd != CMD_WHOLE_ERASE) |-> $past(bitcnt) == 13'(ADDR_CMD_BITS))
        else $error("erase with wrong clock count");

    whole_len_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (ego && cmd == CMD_WHOLE_ERASE) |-> $past(bitcnt) == 13'(CMD_BITS))
        else $error("whole erase with wrong clock count");

    sub_prot_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (pgo && cfg.small_sector_mode && oaddr[ADDR_W-1:12] == '0)
        |-> !cfg.sub_sector_protect[oaddr[11:10]])
        else $error("protected sub-sector programmed");

    nv_wel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $changed(nv) |-> $past(write_enable_latch)) else $error("status written without latch");

    cfg_wel_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $changed(cfg.sub_sector_protect) |-> $past(write_enable_latch))
        else $error("config written without latch");

    op_idle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (pgo || ego) |-> !$past(write_in_progress)) else $error("operation started while busy");
endmodule : sfwp_core

// ===== sim/sfwp_spi_master.sv
// spi master model that drives the flash block's serial pins
`timescale 1ns/100ps
module sfwp_spi_master (
    // clock
    input wire logic clk_i,
    // spi pins
    output logic ce_b_o,
    output logic sck_o,
    output logic si_o,
    input wire logic so_i
);
    initial begin
        ce_b_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    // sck half period of 4 clocks gives the 800 ns link period
    task automatic half();
        repeat (4) @(negedge clk_i);
    endtask : half
    // one frame of n clocks, msb first; the caller keeps the frame whole
    task automatic frame(input logic [47:0] bits, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge clk_i);
        ce_b_o = 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            si_o = bits[i];
            half();
            rd = {rd[6:0], so_i};
            sck_o = 1'b1;
            half();
            sck_o = 1'b0;
        end
        half();
        ce_b_o = 1'b1;
        // released line must not keep showing the last bit
        si_o = ~si_o;
        half();
        half();
    endtask : frame
endmodule : sfwp_spi_master

// ===== sim/sfwp_core_bench.sv
// self-checking bench for the flash write-protection block
`timescale 1ns/100ps
module sfwp_core_bench;
    import sfwp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wp_b = 1'b1;
    logic ce_b, sck, si, so, so_oe, prog_go, erase_go;
    logic [18:0] op_addr;
    logic [7:0] rd;
    int fail_count = 0;
    int n_compared = 0;
    int n_prog = 0;
    int n_erase = 0;
    int n_oe = 0;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (prog_go === 1'b1) n_prog++;
        if (erase_go === 1'b1) n_erase++;
        if (so_oe === 1'b1) n_oe++;
    end
    // long busy time so that frames land inside the write cycle
    sfwp_core #(.ADDR_W(19), .BP_BITS(3), .WRITE_CYC(400)) DUT (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_b_i(ce_b), .sck_i(sck), .si_i(si),
        .wp_b_i(wp_b), .so_o(so), .so_oe_o(so_oe), .prog_go_o(prog_go),
        .erase_go_o(erase_go), .op_addr_o(op_addr));
    sfwp_spi_master spi (.clk_i(clk_i), .ce_b_o(ce_b), .sck_o(sck), .si_o(si), .so_i(so));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic cmd(input logic [7:0] c);
        spi.frame({40'h0, c}, 8, rd);
    endtask : cmd
    task automatic rdreg(input logic [7:0] c);
        spi.frame({32'h0, c, 8'h00}, 16, rd);
    endtask : rdreg
    task automatic wait_ready();
        for (int k = 0; k < 40; k++) begin
            rdreg(CMD_READ_STATUS);
            if (rd[0] === 1'b0) break;
        end
    endtask : wait_ready
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        cmd(CMD_WRITE_ENABLE);
        spi.frame({32'h0, c, d}, 16, rd);
    endtask : wr
    // enabled array operation, then pulse counts against the expected ones
    task automatic op(input logic [47:0] bits, input int n, input int ep, input int ee);
        int p0;
        int e0;
        p0 = n_prog;
        e0 = n_erase;
        cmd(CMD_WRITE_ENABLE);
        spi.frame(bits, n, rd);
        wait_ready();
        check("program pulses", 32'(n_prog - p0), 32'(ep));
        check("erase pulses", 32'(n_erase - e0), 32'(ee));
    endtask : op
    initial begin
        #5_000_000;
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (12) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge clk_i);
        rdreg(CMD_READ_STATUS);
        check("status", rd, 8'h00);
        check("so driven", 32'(n_oe != 0), 32'h1);
        check("so released", so_oe, 1'b0);
        rdreg(CMD_READ_CONFIG);
        check("config", rd, 8'h00);
        spi.frame({32'h0, CMD_WRITE_STATUS, 8'h1C}, 16, rd);
        rdreg(CMD_READ_STATUS);
        check("status", rd, 8'h00);
        cmd(CMD_WRITE_ENABLE);
        rdreg(CMD_READ_STATUS);
        check("status", rd, 8'h02);
        cmd(CMD_WRITE_DISABLE);
        rdreg(CMD_READ_STATUS);
        check("status", rd, 8'h00);
        wr(CMD_WRITE_CONFIG, 8'h01);
        wait_ready();
        rdreg(CMD_READ_CONFIG);
        check("config", rd, 8'h00);
        wr(CMD_WRITE_STATUS, 8'h1C);
        rdreg(CMD_READ_STATUS);
        check("busy", rd[0], 1'b1);
        cmd(CMD_WRITE_ENABLE);
        wait_ready();
        rdreg(CMD_READ_STATUS);
        check("status", rd, 8'h1C);
        wr(CMD_WRITE_CONFIG, 8'h03);
        wait_ready();
        rdreg(CMD_READ_CONFIG);
        check("config", rd, 8'h03);
        op({8'h00, CMD_PAGE_PROG, 24'h000000, 8'hA5}, 40, 0, 0);
        op({8'h00, CMD_PAGE_PROG, 24'h000400, 8'hA5}, 40, 1, 0);
        check("operation address", op_addr, 19'h00400);
        op({8'h00, CMD_PAGE_PROG, 24'h001000, 8'hA5}, 40, 0, 0);
        op({40'h0, CMD_WHOLE_ERASE}, 8, 0, 0);
        wr(CMD_WRITE_STATUS, 8'h04);
        wait_ready();
        op({8'h00, CMD_PAGE_PROG, 24'h070000, 8'hA5}, 40, 0, 0);
        op({8'h00, CMD_PAGE_PROG, 24'h06FF00, 8'hA5}, 40, 1, 0);
        op({9'h000, CMD_PAGE_PROG, 24'h06FF00, 7'h25}, 39, 0, 0);
        op({16'h0, CMD_SECTOR_ERASE, 24'h070000}, 32, 0, 0);
        op({16'h0, CMD_BLOCK_ERASE, 24'h060000}, 32, 0, 1);
        check("operation address", op_addr, 19'h60000);
        wr(CMD_WRITE_STATUS, 8'h00);
        wait_ready();
        rdreg(CMD_READ_CONFIG);
        check("small sector mode", rd[0], 1'b0);
        op({40'h0, CMD_WHOLE_ERASE}, 8, 0, 1);
        check("operation address", op_addr, 19'h00000);
        wr(CMD_WRITE_STATUS, 8'h80);
        wait_ready();
        wp_b = 1'b0;
        wr(CMD_WRITE_STATUS, 8'h0C);
        wait_ready();
        rdreg(CMD_READ_STATUS);
        check("status", rd, 8'h80);
        wp_b = 1'b1;
        wr(CMD_WRITE_STATUS, 8'h00);
        wait_ready();
        rdreg(CMD_READ_STATUS);
        check("status", rd, 8'h00);
        stop_test();
    end
endmodule : sfwp_core_bench
